// >>> flash_guard_regs.svh
// Offsets, field positions and reset values of the flash access protection
`ifndef FLASH_GUARD_REGS_SVH
`define FLASH_GUARD_REGS_SVH

// Register indexes; byte address is four times the index
`define IDX_INFO_BLOCK_INDEX 16'hf880
`define IDX_INFO_BLOCK_DATA 16'hf882
`define IDX_CORE_BLOCK_WRITE_GUARD 16'hf890
`define IDX_GUARD_CTRL 16'hf8a0
`define IDX_GUARD_STATUS 16'hf8a2
`define IDX_PROTECTION_WORD 16'hf8a4

// Reset values
`define GUARD_RST 16'h0000
`define CTRL_RST 3'h0

// Control register bits
`define CTRL_VIOL_IEN 0
`define CTRL_HOST_READ_EN 1
`define CTRL_HOST_WRITE_EN 2

// Status register bits
`define STAT_VIOL 0
`define STAT_PROTECT 1
`define STAT_FETCHED 2

// Protection word fields
`define PW_CONTENTS_MSB 9
`define PW_CONTENTS_LSB 7
`define PW_CONTENTS_OPEN 3'h7
`define PW_HOST_BOOT_BIT 4
`define PW_CORE_BOOT_MSB 3
`define PW_CORE_BOOT_LSB 0

// Information block layout, byte addresses
`define INFO_FACTORY_LAST 8'h7f
`define INFO_PROT_WORD_ADDR 8'h80

// Main array geometry
`define BLOCK_ADDR_MSB 16
`define BLOCK_ADDR_LSB 13
`define HOST_BOOT_BLOCKS 8

`endif

// >>> flash_guard_pkg.sv
// Types shared by the flash access protection logic
package flash_guard_pkg;

    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_PROG = 2'b01,
        OP_ERASE = 2'b10,
        OP_SPECIAL = 2'b11
    } op_e;

    typedef enum logic [2:0] {
        SRC_CORE = 3'b000,
        SRC_HOST = 3'b001,
        SRC_JTAG = 3'b010,
        SRC_PAR = 3'b011,
        SRC_BUS = 3'b100,
        SRC_FETCH = 3'b101
    } src_e;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } state_e;

    // One flash request or command; info selects the information block
    typedef struct packed {
        logic valid;
        op_e op;
        logic info;
        logic [16:0] addr;
        logic [15:0] wdata;
        logic byteMode;
    } flash_req_s;

    typedef struct packed {
        state_e st;
        src_e src;
        logic fetched;
        logic [15:0] protWord;
        logic [15:0] guard;
        logic [7:0] index;
        logic [2:0] ctrl;
        logic viol;
        logic irq;
        logic holdReset;
        flash_req_s cmd;
        logic [3:0] respValid;
        logic [3:0] respDenied;
        logic [15:0] respData;
        logic dSel;
        logic dWrite;
        logic [15:0] dIdx;
        logic dByte;
        logic busPend;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } state_s;

endpackage

// >>> flash_access_protection.sv
// Flash access protection with AHB-Lite register slave
`timescale 1ns/100ps
`include "flash_guard_regs.svh"

// Function
// - Read the protection word from the info block before serving any flash request.
// - Core reads of flash are never blocked.
// - Program or erase to a protected block is dropped and answered as denied.
// - A core write-protect violation raises the interrupt when enabled.
// - Core write protection works per 8 Kbyte main-array block.
// - Core never programs or erases factory page or protection word.
// - All block permit bits clear to zero at reset.
// - Core and host boot blocks read-only to core and host, permit bits ignored.
// - Core may not issue special erase.
// - Host main-array access gated by protection word and core settings.
// - Host access to the information block is refused.
// - Contents protect not all ones: debug port gets only special erase.
// - Protected in debug environments: core held in reset until erase.
// - Open contents: debug port free, except factory page writes.
// - Parallel programmer gated exactly like the debug port.
// - Index holds byte address 7-0; words need even address.
// - Data register moves the byte or word at the index.
// - Permit bit i covers block at i times 0x2000; 1 allows writes.
// - Contents field bits 9-7; only 111 means unprotected.
module flash_access_protection #(
    parameter int FLASH_BLOCKS = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Requesters: 0 core, 1 host, 2 debug port, 3 parallel programmer
    input wire flash_guard_pkg::flash_req_s [3:0] req,
    output logic [3:0] respValid,
    output logic [3:0] respDenied,
    output logic [15:0] respData,
    // Flash array command port
    output flash_guard_pkg::flash_req_s flashCmd,
    input wire logic flashAck,
    input wire logic [15:0] flashRdData,
    // Environment and system
    input wire logic onboard_debug_environment,
    input wire logic development_environment,
    output logic coreHoldReset,
    output logic violIrq
);

    flash_guard_pkg::state_s s;
    flash_guard_pkg::state_s n;

    // ------------------------------------------------------------
    // Protection decisions
    // ------------------------------------------------------------
    function automatic logic contentsOpen(input logic [15:0] pw);
        return pw[`PW_CONTENTS_MSB:`PW_CONTENTS_LSB] == `PW_CONTENTS_OPEN;
    endfunction

    function automatic logic inHostBoot(input logic [15:0] pw,
                                        input logic [3:0] blk);
        return !pw[`PW_HOST_BOOT_BIT] &&
            ({1'b0, blk} >= 5'(FLASH_BLOCKS - `HOST_BOOT_BLOCKS));
    endfunction

    function automatic logic inCoreBoot(input logic [15:0] pw,
                                        input logic [3:0] blk);
        return blk < pw[`PW_CORE_BOOT_MSB:`PW_CORE_BOOT_LSB];
    endfunction

    // Factory page and both bytes of the protection word
    function automatic logic infoLocked(input logic [7:0] a);
        return (a <= `INFO_FACTORY_LAST) ||
            (a[7:1] == `INFO_PROT_WORD_ADDR >> 1);
    endfunction

    function automatic logic allowed(input flash_guard_pkg::src_e src,
                                     input flash_guard_pkg::flash_req_s r,
                                     input logic [15:0] pw,
                                     input logic [15:0] guard,
                                     input logic [2:0] ctrl);
        logic [3:0] blk;
        logic isRead;
        logic ok;
        blk = r.addr[`BLOCK_ADDR_MSB:`BLOCK_ADDR_LSB];
        isRead = r.op == flash_guard_pkg::OP_READ;
        ok = 1'b0;
        unique case (src)
            flash_guard_pkg::SRC_CORE: begin
                if (isRead) begin
                    ok = 1'b1;
                end else if (r.op == flash_guard_pkg::OP_SPECIAL) begin
                    ok = 1'b0;
                end else if (r.info) begin
                    ok = !infoLocked(r.addr[7:0]);
                end else begin
                    ok = guard[blk] && !inCoreBoot(pw, blk) &&
                        !inHostBoot(pw, blk);
                end
            end
            flash_guard_pkg::SRC_HOST: begin
                if (r.info || r.op == flash_guard_pkg::OP_SPECIAL) begin
                    ok = 1'b0;
                end else if (isRead) begin
                    ok = ctrl[`CTRL_HOST_READ_EN];
                end else begin
                    ok = ctrl[`CTRL_HOST_WRITE_EN] &&
                        !inCoreBoot(pw, blk) && !inHostBoot(pw, blk);
                end
            end
            default: begin
                // Debug port and parallel programmer share one scheme
                if (!contentsOpen(pw)) begin
                    ok = r.op == flash_guard_pkg::OP_SPECIAL;
                end else if (isRead || r.op == flash_guard_pkg::OP_SPECIAL) begin
                    ok = 1'b1;
                end else begin
                    ok = !(r.info &&
                        r.addr[7:0] <= `INFO_FACTORY_LAST);
                end
            end
        endcase
        return ok;
    endfunction

    function automatic logic [31:0] readMux(input flash_guard_pkg::state_s q,
                                            input logic [15:0] idx);
        logic [31:0] d;
        d = 32'h0;
        unique case (idx)
            `IDX_INFO_BLOCK_INDEX: d = {24'h0, q.index};
            `IDX_CORE_BLOCK_WRITE_GUARD: d = {16'h0, q.guard};
            `IDX_GUARD_CTRL: d = {29'h0, q.ctrl};
            `IDX_GUARD_STATUS: d = {29'h0, q.fetched,
                !contentsOpen(q.protWord), q.viol};
            `IDX_PROTECTION_WORD: d = {16'h0, q.protWord};
            default: d = 32'h0;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        flash_guard_pkg::flash_req_s r;
        logic aligned;
        logic ok;
        int unsigned k;
        r = '0;
        aligned = 1'b0;
        ok = 1'b0;
        k = 0;
        n = s;
        n.respValid = 4'h0;
        n.respDenied = 4'h0;

        // Bus data phase for plain registers
        if (s.dSel) begin
            n.dSel = 1'b0;
            if (s.dWrite) begin
                unique case (s.dIdx)
                    `IDX_INFO_BLOCK_INDEX: n.index = hwdata[7:0];
                    `IDX_CORE_BLOCK_WRITE_GUARD: n.guard = hwdata[15:0];
                    `IDX_GUARD_CTRL: n.ctrl = hwdata[2:0];
                    `IDX_GUARD_STATUS: begin
                        if (hwdata[`STAT_VIOL]) begin
                            n.viol = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Bus address phase
        if (hsel && htrans[1] && hready) begin
            n.dSel = 1'b1;
            n.dWrite = hwrite;
            n.dIdx = haddr[17:2];
            n.dByte = hsize == 3'h0;
            n.hrdata = readMux(s, haddr[17:2]);
            if (haddr[17:2] == `IDX_INFO_BLOCK_DATA) begin
                // Flash access stretches the data phase
                n.busPend = 1'b1;
                n.hreadyout = 1'b0;
            end
        end

        unique case (s.st)
            flash_guard_pkg::ST_FETCH: begin
                n.cmd = '0;
                n.cmd.valid = 1'b1;
                n.cmd.op = flash_guard_pkg::OP_READ;
                n.cmd.info = 1'b1;
                n.cmd.addr = {9'h0, `INFO_PROT_WORD_ADDR};
                n.src = flash_guard_pkg::SRC_FETCH;
                n.st = flash_guard_pkg::ST_BUSY;
            end
            flash_guard_pkg::ST_IDLE: begin
                // Idle while last answer is out, so a held request
                // is not taken twice
                if (s.respValid == 4'h0) begin
                    if (s.busPend && !s.dSel) begin
                        aligned = s.dByte || !s.index[0];
                        r = '0;
                        r.valid = 1'b1;
                        r.op = s.dWrite ? flash_guard_pkg::OP_PROG :
                            flash_guard_pkg::OP_READ;
                        r.info = 1'b1;
                        r.addr = {9'h0, s.index};
                        r.wdata = hwdata[15:0];
                        r.byteMode = s.dByte;
                        ok = aligned && allowed(flash_guard_pkg::SRC_CORE,
                            r, s.protWord, s.guard, s.ctrl);
                        if (ok) begin
                            n.cmd = r;
                            n.src = flash_guard_pkg::SRC_BUS;
                            n.st = flash_guard_pkg::ST_BUSY;
                        end else begin
                            // Misaligned or locked: dropped, data phase ends
                            n.viol = s.viol || (aligned && s.dWrite);
                            n.hrdata = 32'h0;
                            n.busPend = 1'b0;
                            n.hreadyout = 1'b1;
                        end
                    end else begin
                        // Fixed priority: core, host, debug, parallel
                        for (k = 0; k < 4; k++) begin
                            if (req[k].valid && !r.valid) begin
                                r = req[k];
                                ok = allowed(flash_guard_pkg::src_e'(k), r,
                                    s.protWord, s.guard, s.ctrl);
                                if (ok) begin
                                    n.cmd = r;
                                    n.src = flash_guard_pkg::src_e'(k);
                                    n.st = flash_guard_pkg::ST_BUSY;
                                end else begin
                                    n.respValid[k] = 1'b1;
                                    n.respDenied[k] = 1'b1;
                                    if (k == 0 &&
                                        r.op != flash_guard_pkg::OP_READ) begin
                                        n.viol = 1'b1;
                                    end
                                end
                            end
                        end
                    end
                end
            end
            flash_guard_pkg::ST_BUSY: begin
                if (flashAck) begin
                    n.cmd.valid = 1'b0;
                    n.st = flash_guard_pkg::ST_IDLE;
                    unique case (s.src)
                        flash_guard_pkg::SRC_FETCH: begin
                            n.protWord = flashRdData;
                            n.fetched = 1'b1;
                        end
                        flash_guard_pkg::SRC_BUS: begin
                            n.hrdata = s.cmd.byteMode ?
                                {24'h0, flashRdData[7:0]} :
                                {16'h0, flashRdData};
                            n.busPend = 1'b0;
                            n.hreadyout = 1'b1;
                        end
                        default: begin
                            n.respValid[s.src[1:0]] = 1'b1;
                            n.respData = flashRdData;
                            if (s.cmd.op == flash_guard_pkg::OP_SPECIAL) begin
                                // Erased array: word is read again
                                n.st = flash_guard_pkg::ST_FETCH;
                                n.fetched = 1'b0;
                            end
                        end
                    endcase
                end
            end
            default: n.st = flash_guard_pkg::ST_FETCH;
        endcase

        n.irq = n.viol && n.ctrl[`CTRL_VIOL_IEN];
        n.holdReset = !n.fetched || (!contentsOpen(n.protWord) &&
            (onboard_debug_environment ||
            development_environment));
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.st <= flash_guard_pkg::ST_FETCH;
            s.src <= flash_guard_pkg::SRC_FETCH;
            s.guard <= `GUARD_RST;
            s.ctrl <= `CTRL_RST;
            s.holdReset <= 1'b1;
            s.hreadyout <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign hrdata = s.hrdata;
    assign respValid = s.respValid;
    assign respDenied = s.respDenied;
    assign respData = s.respData;
    assign flashCmd = s.cmd;
    assign coreHoldReset = s.holdReset;
    assign violIrq = s.irq;

endmodule

// >>> flash_guard_properties.sv
// Concurrent checks on the ports of the flash access protection
`timescale 1ns/100ps
module flash_guard_properties #(
    parameter int FLASH_BLOCKS = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Requesters and flash command
    input wire flash_guard_pkg::flash_req_s [3:0] req,
    input wire logic [3:0] respValid,
    input wire logic [3:0] respDenied,
    input wire flash_guard_pkg::flash_req_s flashCmd,
    input wire logic flashAck,
    // Environment and system
    input wire logic onboard_debug_environment,
    input wire logic development_environment,
    input wire logic coreHoldReset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_hold_in_reset;
        $fell(sys_rst) |-> coreHoldReset;
    endproperty
    a_hold_in_reset: assert property (p_hold_in_reset)
        else $error("core not held after reset");

    property p_fetch_first;
        $fell(sys_rst) |-> ##[1:2] (flashCmd.valid && flashCmd.info
            && flashCmd.addr[7:0] == 8'h80
            && flashCmd.op == flash_guard_pkg::OP_READ);
    endproperty
    a_fetch_first: assert property (p_fetch_first)
        else $error("protection word not fetched first");

    property p_fetch_release;
        flashAck && flashCmd.info && flashCmd.addr[7:0] == 8'h80
            && coreHoldReset && !onboard_debug_environment
            && !development_environment |-> ##[1:2] !coreHoldReset;
    endproperty
    a_fetch_release: assert property (p_fetch_release)
        else $error("core not released after word fetch");

    property p_core_read;
        respValid[0] && req[0].op == flash_guard_pkg::OP_READ
            |-> !respDenied[0];
    endproperty
    a_core_read: assert property (p_core_read)
        else $error("core read refused");

    property p_core_special;
        respValid[0] && req[0].op == flash_guard_pkg::OP_SPECIAL
            |-> respDenied[0];
    endproperty
    a_core_special: assert property (p_core_special)
        else $error("core special erase accepted");

    property p_core_factory;
        respValid[0] && req[0].info && req[0].addr[7:0] <= 8'h81
            && req[0].op != flash_guard_pkg::OP_READ |-> respDenied[0];
    endproperty
    a_core_factory: assert property (p_core_factory)
        else $error("core changed factory page");

    property p_host_info;
        respValid[1] && req[1].info |-> respDenied[1];
    endproperty
    a_host_info: assert property (p_host_info)
        else $error("host reached info block");

    property p_host_special;
        respValid[1] && req[1].op == flash_guard_pkg::OP_SPECIAL
            |-> respDenied[1];
    endproperty
    a_host_special: assert property (p_host_special)
        else $error("host special erase accepted");

    property p_dbg_factory;
        respValid[2] && req[2].info && req[2].addr[7:0] <= 8'h7f
            && req[2].op inside {flash_guard_pkg::OP_PROG,
            flash_guard_pkg::OP_ERASE} |-> respDenied[2];
    endproperty
    a_dbg_factory: assert property (p_dbg_factory)
        else $error("debug port changed factory page");

    property p_deny_quiet;
        |respDenied |-> (respDenied & ~respValid) == 4'h0
            && !flashCmd.valid;
    endproperty
    a_deny_quiet: assert property (p_deny_quiet)
        else $error("refused request reached the flash");
endmodule

bind flash_access_protection flash_guard_properties #(
    .FLASH_BLOCKS(FLASH_BLOCKS)
) i_props (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .req(req),
    .respValid(respValid),
    .respDenied(respDenied),
    .flashCmd(flashCmd),
    .flashAck(flashAck),
    .onboard_debug_environment(onboard_debug_environment),
    .development_environment(development_environment),
    .coreHoldReset(coreHoldReset)
);

// >>> flash_array_model.sv
// Behavioural flash array answering the protection block's commands
`timescale 1ns/100ps
module flash_array_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Command port
    input wire flash_guard_pkg::flash_req_s flashCmd,
    output logic flashAck,
    output logic [15:0] flashRdData,
    // Contents and pacing
    input wire logic [15:0] protWordImg,
    input wire logic [3:0] ackDelay
);
    logic [3:0] waitCnt;

    always @(posedge ref_clk) begin
        flashAck <= 1'b0;
        // Idle data keeps toggling so a stale word never looks valid
        flashRdData <= ~flashRdData;
        if (sys_rst) begin
            waitCnt <= 4'h0;
            flashRdData <= 16'h0;
        end else if (flashCmd.valid && !flashAck) begin
            waitCnt <= waitCnt + 4'h1;
            if (waitCnt >= ackDelay) begin
                flashAck <= 1'b1;
                waitCnt <= 4'h0;
                if (flashCmd.info && flashCmd.addr[7:0] == 8'h80)
                    flashRdData <= protWordImg;
                else
                    flashRdData <= {8'h5a, flashCmd.addr[7:0]};
            end
        end
    end
endmodule

// >>> tb_flash_access_protection.sv
// Self-checking bench for the flash access protection
`timescale 1ns/100ps
`include "flash_guard_regs.svh"
module tb_flash_access_protection;
    typedef struct packed {
        logic [1:0] k;
        flash_guard_pkg::op_e op;
        logic info;
        logic [16:0] addr;
        logic deny;
    } row_s;
    localparam flash_guard_pkg::op_e RD = flash_guard_pkg::OP_READ;
    localparam flash_guard_pkg::op_e PG = flash_guard_pkg::OP_PROG;
    localparam flash_guard_pkg::op_e ER = flash_guard_pkg::OP_ERASE;
    localparam flash_guard_pkg::op_e SP = flash_guard_pkg::OP_SPECIAL;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic ref_clk, sys_rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    flash_guard_pkg::flash_req_s [3:0] req;
    flash_guard_pkg::flash_req_s flashCmd;
    logic [3:0] respValid, respDenied, ackDelay;
    logic [15:0] respData, flashRdData, protWordImg;
    logic flashAck, onboardEnv, devEnv, coreHoldReset, violIrq;
    int nMismatch = 0;
    int totalChecks = 0;
    // Guard 0x0007, boot area is block 0
    row_s rows [12] = '{
        '{2'h0, RD, 1'b0, 17'h00100, 1'b0},
        '{2'h0, PG, 1'b0, 17'h02000, 1'b0},
        '{2'h0, ER, 1'b0, 17'h06000, 1'b1},
        '{2'h0, PG, 1'b0, 17'h00010, 1'b1},
        '{2'h0, SP, 1'b0, 17'h00000, 1'b1},
        '{2'h0, PG, 1'b1, 17'h00010, 1'b1},
        '{2'h1, RD, 1'b1, 17'h00010, 1'b1},
        '{2'h1, RD, 1'b0, 17'h04000, 1'b0},
        '{2'h1, SP, 1'b0, 17'h00000, 1'b1},
        '{2'h2, RD, 1'b1, 17'h00010, 1'b0},
        '{2'h2, PG, 1'b1, 17'h00010, 1'b1},
        '{2'h3, ER, 1'b0, 17'h0a000, 1'b0}
    };

    flash_access_protection i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req(req),
        .respValid(respValid), .respDenied(respDenied),
        .respData(respData), .flashCmd(flashCmd), .flashAck(flashAck),
        .flashRdData(flashRdData), .onboard_debug_environment(onboardEnv),
        .development_environment(devEnv), .coreHoldReset(coreHoldReset),
        .violIrq(violIrq));
    flash_array_model i_flash (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .flashCmd(flashCmd), .flashAck(flashAck), .flashRdData(flashRdData),
        .protWordImg(protWordImg), .ackDelay(ackDelay));

    always #5 ref_clk = ~ref_clk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
            input string msg);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: %s got %h", $time, msg, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wait_ready();
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            @(posedge ref_clk);
        end
    endtask

    task automatic bus(input logic wr, input logic [15:0] idx,
            input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= wd[31] ? 3'h0 : 3'h2; // wd[31] picks byte
        haddr <= {14'h0, idx, 2'h0};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic ask(input row_s r, output logic den,
            output logic [15:0] dat, output logic sent);
        sent = 1'b0;
        req[r.k] <= '{1'b1, r.op, r.info, r.addr, 16'h0f0f, 1'b0};
        @(posedge ref_clk);
        while (respValid[r.k] !== 1'b1) begin
            if (flashCmd.valid === 1'b1)
                sent = 1'b1;
            @(posedge ref_clk);
        end
        den = respDenied[r.k];
        dat = respData;
        req[r.k] <= '0;
        @(posedge ref_clk);
    endtask

    task automatic do_reset();
        int n;
        n = 0;
        sys_rst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check({31'h0, coreHoldReset}, 32'h1, "hold");
        while (coreHoldReset !== 1'b0 && n < 40) begin
            n++;
            @(posedge ref_clk);
        end
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        #100000;
        nMismatch++;
        $display("mismatch at %0t: timeout", $time);
        end_sim();
    end

    initial begin
        logic [31:0] rd;
        logic [15:0] dat;
        logic den, sent;
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        req = '0;
        {onboardEnv, devEnv} = 2'h0;
        protWordImg = 16'h0391;
        ackDelay = 4'h0;
        do_reset();
        check({31'h0, coreHoldReset}, 32'h0, "release");
        bus(1'b0, `IDX_CORE_BLOCK_WRITE_GUARD, 32'h0, rd);
        check(rd, 32'h0, "guard reset");
        bus(1'b0, 16'hf8f0, 32'h0, rd);
        check(rd, 32'h0, "unmapped");
        bus(1'b1, `IDX_CORE_BLOCK_WRITE_GUARD, 32'h7, rd);
        bus(1'b1, `IDX_GUARD_CTRL, 32'h7, rd);
        bus(1'b0, `IDX_CORE_BLOCK_WRITE_GUARD, 32'h0, rd);
        check(rd, 32'h7, "guard");
        check({31'h0, hresp}, 32'h0, "hresp");
        for (int i = 0; i < 12; i++) begin
            ask(rows[i], den, dat, sent);
            check({31'h0, den}, {31'h0, rows[i].deny}, "deny");
            check({31'h0, sent}, {31'h0, ~rows[i].deny}, "sent");
            if (!rows[i].deny && rows[i].op == RD)
                check({16'h0, dat}, {24'h5a, rows[i].addr[7:0]}, "rd");
        end
        $display("test requesters done");
        bus(1'b0, `IDX_GUARD_STATUS, 32'h0, rd);
        check(rd, 32'h5, "status");
        check({31'h0, violIrq}, 32'h1, "irq");
        bus(1'b1, `IDX_GUARD_STATUS, 32'h1, rd);
        repeat (2) @(posedge ref_clk);
        check({31'h0, violIrq}, 32'h0, "irq clear");
        ackDelay <= 4'h3;
        bus(1'b1, `IDX_INFO_BLOCK_INDEX, 32'h84, rd);
        bus(1'b0, `IDX_INFO_BLOCK_DATA, 32'h0, rd);
        check(rd, 32'h5a84, "info word");
        bus(1'b1, `IDX_INFO_BLOCK_INDEX, 32'h85, rd);
        bus(1'b0, `IDX_INFO_BLOCK_INDEX, 32'h0, rd);
        check(rd, 32'h85, "index");
        bus(1'b0, `IDX_INFO_BLOCK_DATA, 32'h0, rd);
        check(rd, 32'h0, "odd word");
        bus(1'b0, `IDX_INFO_BLOCK_DATA, 32'h80000000, rd);
        check(rd, 32'h85, "odd byte");
        bus(1'b1, `IDX_INFO_BLOCK_INDEX, 32'h10, rd);
        bus(1'b1, `IDX_INFO_BLOCK_DATA, 32'h1234, rd);
        bus(1'b0, `IDX_GUARD_STATUS, 32'h0, rd);
        check(rd, 32'h5, "factory write");
        $display("test info block done");
        protWordImg <= 16'h0191;
        onboardEnv <= 1'b1;
        do_reset();
        check({31'h0, coreHoldReset}, 32'h1, "held");
        bus(1'b0, `IDX_GUARD_STATUS, 32'h0, rd);
        check(rd, 32'h6, "protected");
        ask('{2'h2, RD, 1'b0, 17'h04000, 1'b0}, den, dat, sent);
        check({31'h0, den}, 32'h1, "debug read");
        ask('{2'h3, RD, 1'b0, 17'h04000, 1'b0}, den, dat, sent);
        check({31'h0, den}, 32'h1, "parallel read");
        protWordImg <= 16'h0391;
        ask('{2'h2, SP, 1'b0, 17'h00000, 1'b0}, den, dat, sent);
        check({31'h0, den}, 32'h0, "special");
        repeat (12) @(posedge ref_clk);
        check({31'h0, coreHoldReset}, 32'h0, "erased");
        $display("test protection done");
        end_sim();
    end
endmodule
